// >>> hdl/sptcr_pkg.sv
package sptcr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LEN_W = 11;
  localparam int CNT_W = 12;
  localparam logic [ADDR_W-1:0] FWD_CTRL_OFS = 8'h86;
  localparam logic [ADDR_W-1:0] DEF_TAG_OFS = 8'h88;
  localparam logic [ADDR_W-1:0] LIM_CTRL_OFS = 8'h8A;
  // forwarding control fields
  localparam int FC_VLAN_FILT = 14;
  localparam int FC_NON_DEF_VID_DROP = 13;
  localparam int FC_FORCE_FLOW = 12;
  localparam int FC_BACK_PRESS = 11;
  localparam int FC_TX_EN = 10;
  localparam int FC_RX_EN = 9;
  localparam int FC_LEARN_DIS = 8;
  localparam int FC_SNIFFER = 7;
  localparam int FC_RX_SNIFF = 6;
  localparam int FC_TX_SNIFF = 5;
  localparam int FC_PRIO_CEIL = 3;
  localparam int FC_MEMB_HI = 2;
  localparam int FC_MEMB_LO = 0;
  localparam logic [DATA_W-1:0] FWD_CTRL_RST = 16'h0607;
  // default tag fields
  localparam int DT_PRIO_HI = 15;
  localparam int DT_PRIO_LO = 13;
  localparam int DT_CFI = 12;
  localparam int DT_VID_HI = 11;
  localparam int DT_VID_LO = 0;
  localparam logic [DATA_W-1:0] DEF_TAG_RST = 16'h0001;
  // limit mode control fields, bits above LM_IMPL_HI are read-only zero
  localparam int LM_IMPL_HI = 4;
  localparam int LM_MODE_HI = 3;
  localparam int LM_MODE_LO = 2;
  localparam int LM_IFG = 1;
  localparam int LM_PREAMBLE = 0;
  localparam logic [LM_IMPL_HI:0] LIM_CTRL_RST = 5'h00;
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_BC_MC_FLOOD = 2'h1;
  localparam logic [1:0] MODE_BC_MC = 2'h2;
  localparam logic [1:0] MODE_BC = 2'h3;
  localparam logic [CNT_W-1:0] IFG_BYTES = 12'h00C;
  localparam logic [CNT_W-1:0] PREAMBLE_BYTES = 12'h008;
  // membership bit positions
  localparam int PORT_ONE_BIT = 0;
  localparam int PORT_TWO_BIT = 1;
  localparam int HOST_BIT = 2;
  localparam logic [11:0] NULL_VID = 12'h000;
endpackage : sptcr_pkg

// >>> hdl/sptcr_port_two_regs.sv
// Summary of operation
// - vlan filtering drops non-member ingress packets
// - drop packets not matching default vlan
// - forced flow control overrides negotiation
// - back pressure only in half duplex
// - transmit enable gates all transmission
// - receive enable gates forwarding, learning and rx mirroring; limit counting still sees the frame
// - learning disable stops address learning
// - sniffer port transmits monitored packets
// - receive sniff marks and mirrors rx
// - transmit sniff marks and mirrors tx
// - priority ceiling clamps packet priority
// - membership mask restricts forwarding targets
// - default tag layout and reset value
// - untagged or null vid gets default vid
// - ingress tag input, not the default tag, used when tagging untagged
// - limit mode selects counted frame kinds
// - add twelve gap bytes when enabled
// - add eight preamble bytes when enabled
// - inserted tag carries ingress default vid
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module sptcr_port_two_regs (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [sptcr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [sptcr_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [sptcr_pkg::DATA_W-1:0] reg_rdata_out,
  // link status from the mac/phy
  input wire logic an_pause_in,
  input wire logic half_duplex_in,
  // ingress packet descriptor
  input wire logic rx_valid_in,
  input wire logic rx_tagged_in,
  input wire logic [11:0] rx_vid_in,
  input wire logic [2:0] rx_prio_in,
  input wire logic [2:0] rx_vlan_member_in,
  input wire logic [2:0] rx_dest_mask_in,
  input wire logic rx_bcast_in,
  input wire logic rx_mcast_in,
  input wire logic rx_flood_in,
  input wire logic [sptcr_pkg::LEN_W-1:0] rx_len_in,
  // egress packet descriptor
  input wire logic tx_valid_in,
  input wire logic tx_arrived_untagged_in,
  input wire logic tx_insert_en_in,
  input wire logic [15:0] tx_ingress_tag_in,
  input wire logic [sptcr_pkg::LEN_W-1:0] tx_len_in,
  // static port controls
  output logic flow_ctrl_en_out,
  output logic back_pressure_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic sniffer_port_out,
  output logic [15:0] default_tag_out,
  output logic [1:0] limit_mode_out,
  // ingress verdict, one cycle after rx_valid_in
  output logic rx_done_out,
  output logic rx_drop_out,
  output logic [11:0] rx_vid_out,
  output logic [2:0] rx_prio_out,
  output logic [2:0] rx_fwd_mask_out,
  output logic rx_monitor_out,
  output logic rx_learn_out,
  output logic rx_limit_count_out,
  output logic [sptcr_pkg::CNT_W-1:0] rx_rate_bytes_out,
  // egress verdict, one cycle after tx_valid_in
  output logic tx_done_out,
  output logic tx_send_out,
  output logic tx_monitor_out,
  output logic tx_add_tag_out,
  output logic [15:0] tx_tag_out,
  output logic [sptcr_pkg::CNT_W-1:0] tx_rate_bytes_out
);
  import sptcr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] fwd_ctrl;
    logic [DATA_W-1:0] def_tag;
    logic [LM_IMPL_HI:0] lim_ctrl;
    logic [DATA_W-1:0] rdata;
    logic flow_en;
    logic back_press;
    logic rx_done;
    logic rx_drop;
    logic [11:0] rx_vid;
    logic [2:0] rx_prio;
    logic [2:0] rx_fwd;
    logic rx_mon;
    logic rx_learn;
    logic rx_lim;
    logic [CNT_W-1:0] rx_bytes;
    logic tx_done;
    logic tx_send;
    logic tx_mon;
    logic tx_add;
    logic [15:0] tx_tag;
    logic [CNT_W-1:0] tx_bytes;
  } sptcr_state_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FWD,
    SEL_TAG,
    SEL_LIM
  } sptcr_reg_sel_t;

  sptcr_state_t st_q;
  sptcr_state_t st_d;

  // shared by ingress and egress rate accounting
  function automatic logic [CNT_W-1:0] frame_bytes(
    input logic [LEN_W-1:0] len,
    input logic [LM_IMPL_HI:0] lim
  );
    logic [CNT_W-1:0] sum;
    sum = {{(CNT_W-LEN_W){1'b0}}, len};
    if (lim[LM_IFG]) begin
      sum = sum + IFG_BYTES;
    end
    if (lim[LM_PREAMBLE]) begin
      sum = sum + PREAMBLE_BYTES;
    end
    return sum;
  endfunction : frame_bytes

  function automatic logic limit_counts(
    input logic [1:0] mode,
    input logic bcast,
    input logic mcast,
    input logic flood
  );
    logic hit;
    case (mode)
      MODE_ALL: begin
        hit = 1'b1;
      end
      MODE_BC_MC_FLOOD: begin
        hit = bcast | mcast | flood;
      end
      MODE_BC_MC: begin
        hit = bcast | mcast;
      end
      MODE_BC: begin
        hit = bcast;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : limit_counts

  // one decoder for both strobes, so reads and writes agree on the map
  function automatic sptcr_reg_sel_t reg_select(
    input logic [ADDR_W-1:0] addr
  );
    sptcr_reg_sel_t sel;
    case (addr)
      FWD_CTRL_OFS: begin
        sel = SEL_FWD;
      end
      DEF_TAG_OFS: begin
        sel = SEL_TAG;
      end
      LIM_CTRL_OFS: begin
        sel = SEL_LIM;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction : reg_select

  // unmapped addresses read zero
  function automatic logic [DATA_W-1:0] read_word(
    input sptcr_reg_sel_t sel,
    input logic [DATA_W-1:0] fwd,
    input logic [DATA_W-1:0] tag,
    input logic [LM_IMPL_HI:0] lim
  );
    logic [DATA_W-1:0] word;
    case (sel)
      SEL_FWD: begin
        word = fwd;
      end
      SEL_TAG: begin
        word = tag;
      end
      SEL_LIM: begin
        word = {{(DATA_W-LM_IMPL_HI-1){1'b0}}, lim};
      end
      default: begin
        word = '0;
      end
    endcase
    return word;
  endfunction : read_word

  // untagged and null id take the default id
  function automatic logic [11:0] effective_vid(
    input logic has_tag,
    input logic [11:0] vid,
    input logic [11:0] def_vid
  );
    logic [11:0] eff;
    eff = vid;
    if (!has_tag || vid == NULL_VID) begin
      eff = def_vid;
    end
    return eff;
  endfunction : effective_vid

  // strictly greater only; equal priority passes
  function automatic logic [2:0] ceiled_prio(
    input logic ceil_en,
    input logic [2:0] prio,
    input logic [2:0] ceiling
  );
    logic [2:0] out_prio;
    out_prio = prio;
    if (ceil_en && prio > ceiling) begin
      out_prio = ceiling;
    end
    return out_prio;
  endfunction : ceiled_prio

  function automatic logic ingress_drop(
    input logic [DATA_W-1:0] fc,
    input logic [2:0] member,
    input logic [11:0] eff_vid,
    input logic [11:0] def_vid
  );
    logic drop;
    drop = 1'b0;
    if (!fc[FC_RX_EN]) begin
      drop = 1'b1;
    end
    if (fc[FC_VLAN_FILT] && !member[PORT_TWO_BIT]) begin
      drop = 1'b1;
    end
    if (fc[FC_NON_DEF_VID_DROP] && eff_vid != def_vid) begin
      drop = 1'b1;
    end
    return drop;
  endfunction : ingress_drop

  // own-port bit left to the core on purpose
  function automatic logic [2:0] forward_targets(
    input logic drop,
    input logic [2:0] dest,
    input logic [2:0] membership
  );
    logic [2:0] targets;
    targets = dest & membership;
    if (drop) begin
      targets = '0;
    end
    return targets;
  endfunction : forward_targets

  always_comb begin
    logic [11:0] def_vid;
    logic [11:0] eff_vid;
    logic drop;
    sptcr_reg_sel_t sel;
    st_d = st_q;
    def_vid = st_q.def_tag[DT_VID_HI:DT_VID_LO];
    eff_vid = effective_vid(rx_tagged_in, rx_vid_in, def_vid);
    drop = ingress_drop(st_q.fwd_ctrl, rx_vlan_member_in, eff_vid, def_vid);
    sel = reg_select(reg_addr_in);

    // register writes; a write first affects packets presented in the following cycle
    if (reg_wr_in) begin
      case (sel)
        SEL_FWD: begin
          st_d.fwd_ctrl = reg_wdata_in;
        end
        SEL_TAG: begin
          st_d.def_tag = reg_wdata_in;
        end
        SEL_LIM: begin
          st_d.lim_ctrl = reg_wdata_in[LM_IMPL_HI:0];
        end
        default: begin
          st_d.fwd_ctrl = st_q.fwd_ctrl;
        end
      endcase
    end

    // read data stand only in the cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd_in) begin
      st_d.rdata = read_word(sel, st_q.fwd_ctrl, st_q.def_tag, st_q.lim_ctrl);
    end

    st_d.flow_en = st_q.fwd_ctrl[FC_FORCE_FLOW] | an_pause_in;
    st_d.back_press = st_q.fwd_ctrl[FC_BACK_PRESS] & half_duplex_in;

    st_d.rx_done = rx_valid_in;
    st_d.rx_drop = rx_valid_in & drop;
    st_d.rx_vid = eff_vid;
    st_d.rx_prio = ceiled_prio(st_q.fwd_ctrl[FC_PRIO_CEIL], rx_prio_in,
      st_q.def_tag[DT_PRIO_HI:DT_PRIO_LO]);
    // membership mask; a dropped packet goes nowhere
    st_d.rx_fwd = forward_targets(drop, rx_dest_mask_in, st_q.fwd_ctrl[FC_MEMB_HI:FC_MEMB_LO]);
    st_d.rx_mon = rx_valid_in & ~drop & st_q.fwd_ctrl[FC_RX_SNIFF];
    st_d.rx_learn = rx_valid_in & ~drop & ~st_q.fwd_ctrl[FC_LEARN_DIS];
    st_d.rx_lim = rx_valid_in & limit_counts(st_q.lim_ctrl[LM_MODE_HI:LM_MODE_LO],
      rx_bcast_in, rx_mcast_in, rx_flood_in);
    st_d.rx_bytes = frame_bytes(rx_len_in, st_q.lim_ctrl);

    st_d.tx_done = tx_valid_in;
    st_d.tx_send = tx_valid_in & st_q.fwd_ctrl[FC_TX_EN];
    st_d.tx_mon = tx_valid_in & st_q.fwd_ctrl[FC_TX_EN] & st_q.fwd_ctrl[FC_TX_SNIFF];
    st_d.tx_add = tx_valid_in & tx_insert_en_in & tx_arrived_untagged_in;
    st_d.tx_tag = tx_ingress_tag_in;
    st_d.tx_bytes = frame_bytes(tx_len_in, st_q.lim_ctrl);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.fwd_ctrl <= FWD_CTRL_RST;
      st_q.def_tag <= DEF_TAG_RST;
      st_q.lim_ctrl <= LIM_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign flow_ctrl_en_out = st_q.flow_en;
  assign back_pressure_out = st_q.back_press;
  assign tx_enable_out = st_q.fwd_ctrl[FC_TX_EN];
  assign rx_enable_out = st_q.fwd_ctrl[FC_RX_EN];
  assign sniffer_port_out = st_q.fwd_ctrl[FC_SNIFFER];
  assign default_tag_out = st_q.def_tag;
  assign limit_mode_out = st_q.lim_ctrl[LM_MODE_HI:LM_MODE_LO];
  assign rx_done_out = st_q.rx_done;
  assign rx_drop_out = st_q.rx_drop;
  assign rx_vid_out = st_q.rx_vid;
  assign rx_prio_out = st_q.rx_prio;
  assign rx_fwd_mask_out = st_q.rx_fwd;
  assign rx_monitor_out = st_q.rx_mon;
  assign rx_learn_out = st_q.rx_learn;
  assign rx_limit_count_out = st_q.rx_lim;
  assign rx_rate_bytes_out = st_q.rx_bytes;
  assign tx_done_out = st_q.tx_done;
  assign tx_send_out = st_q.tx_send;
  assign tx_monitor_out = st_q.tx_mon;
  assign tx_add_tag_out = st_q.tx_add;
  assign tx_tag_out = st_q.tx_tag;
  assign tx_rate_bytes_out = st_q.tx_bytes;
endmodule : sptcr_port_two_regs

// >>> verif/sptcr_port_two_regs_checker.sv
`timescale 1ns/1ps
module sptcr_port_two_regs_checker (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [sptcr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [sptcr_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic an_pause_in,
  input wire logic half_duplex_in,
  input wire logic flow_ctrl_en_out,
  input wire logic back_pressure_out,
  input wire logic rx_valid_in,
  input wire logic [sptcr_pkg::LEN_W-1:0] rx_len_in,
  input wire logic rx_enable_out,
  input wire logic rx_drop_out,
  input wire logic rx_learn_out,
  input wire logic [2:0] rx_fwd_mask_out,
  input wire logic [sptcr_pkg::CNT_W-1:0] rx_rate_bytes_out,
  input wire logic tx_valid_in,
  input wire logic tx_enable_out,
  input wire logic tx_send_out,
  input wire logic [1:0] limit_mode_out
);
  import sptcr_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  chk_flow_force: assert property (an_pause_in |=> flow_ctrl_en_out)
    else $error("flow control off after negotiated pause");
  chk_bp_duplex: assert property (!half_duplex_in |=> !back_pressure_out)
    else $error("back pressure in full duplex");
  chk_rx_gate: assert property (rx_valid_in && !rx_enable_out |=> rx_drop_out)
    else $error("packet kept while reception disabled");
  chk_tx_gate: assert property (tx_valid_in |=> tx_send_out == $past(tx_enable_out))
    else $error("send does not follow transmit enable");
  chk_drop_quiet: assert property (rx_drop_out |-> !rx_learn_out && rx_fwd_mask_out == 3'h0)
    else $error("dropped packet still forwarded or learned");
  chk_rate_extra: assert property (rx_valid_in |=>
    (rx_rate_bytes_out - CNT_W'($past(rx_len_in))) inside {12'h000, 12'h008, 12'h00C, 12'h014})
    else $error("rate byte count has a bad overhead");
  chk_lim_rsvd: assert property (reg_rd_in && reg_addr_in == LIM_CTRL_OFS |=>
    reg_rdata_out[DATA_W-1:LM_IMPL_HI+1] == '0)
    else $error("reserved limit bits read nonzero");
  chk_lim_mode: assert property (reg_rd_in && reg_addr_in == LIM_CTRL_OFS |=>
    reg_rdata_out[LM_MODE_HI:LM_MODE_LO] == $past(limit_mode_out))
    else $error("limit mode readback differs from output");
endmodule : sptcr_port_two_regs_checker

bind sptcr_port_two_regs sptcr_port_two_regs_checker u_chk (.*);

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  import sptcr_pkg::*;
  logic clk_sys_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [ADDR_W-1:0] reg_addr_in = 0;
  logic [DATA_W-1:0] reg_wdata_in = 0, reg_rdata_out;
  logic an_pause_in = 0, half_duplex_in = 0, rx_valid_in = 0, rx_tagged_in = 0;
  logic rx_bcast_in = 0, rx_mcast_in = 0, rx_flood_in = 0, tx_valid_in = 0;
  logic tx_arrived_untagged_in = 0, tx_insert_en_in = 0;
  logic [11:0] rx_vid_in = 0, rx_vid_out, ev;
  logic [2:0] rx_prio_in = 0, rx_vlan_member_in = 0, rx_dest_mask_in = 0;
  logic [2:0] rx_prio_out, rx_fwd_mask_out;
  logic [LEN_W-1:0] rx_len_in = 0, tx_len_in = 0;
  logic [15:0] tx_ingress_tag_in = 0, default_tag_out, tx_tag_out, fc, dt, lm, v;
  logic [1:0] limit_mode_out;
  logic [CNT_W-1:0] rx_rate_bytes_out, tx_rate_bytes_out;
  logic flow_ctrl_en_out, back_pressure_out, tx_enable_out, rx_enable_out, sniffer_port_out;
  logic rx_done_out, rx_drop_out, rx_monitor_out, rx_learn_out, rx_limit_count_out;
  logic tx_done_out, tx_send_out, tx_monitor_out, tx_add_tag_out, dr;
  int bad_count = 0, num_checks = 0;

  sptcr_port_two_regs u_dut (.*);

  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic chk(input string m, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd

  function automatic logic [CNT_W-1:0] rate(input logic [LEN_W-1:0] n);
    rate = CNT_W'(n) + (lm[LM_IFG] ? IFG_BYTES : '0) + (lm[LM_PREAMBLE] ? PREAMBLE_BYTES : '0);
  endfunction : rate

  function automatic logic cnt();
    case (lm[LM_MODE_HI:LM_MODE_LO])
      MODE_ALL: cnt = 1'b1;
      MODE_BC_MC_FLOOD: cnt = rx_bcast_in | rx_mcast_in | rx_flood_in;
      MODE_BC_MC: cnt = rx_bcast_in | rx_mcast_in;
      default: cnt = rx_bcast_in;
    endcase
  endfunction : cnt

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // generous bound, the loop needs under 1500 cycles
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hAD09937D));
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(FWD_CTRL_OFS, v);
    chk("fwd reset", v, FWD_CTRL_RST);
    rd(DEF_TAG_OFS, v);
    chk("tag reset", v, DEF_TAG_RST);
    @(posedge clk_sys_in);
    #1 chk("rdata idle", reg_rdata_out, 16'h0000);
    rd(LIM_CTRL_OFS, v);
    chk("limit reset", v, 16'h0000);
    wr(8'h80, 16'hFFFF);
    rd(8'h80, v);
    chk("unmapped", v, 16'h0000);
    rd(FWD_CTRL_OFS, v);
    chk("unmapped wr", v, FWD_CTRL_RST);
    $display("test reset values done");
    for (int i = 0; i < 60; i++) begin
      fc = 16'($urandom);
      // keep reception on most of the time so other verdicts show
      if (i % 4) fc[FC_RX_EN] = 1'b1;
      dt = 16'($urandom);
      lm = 16'($urandom);
      wr(FWD_CTRL_OFS, fc);
      wr(DEF_TAG_OFS, dt);
      wr(LIM_CTRL_OFS, lm);
      rd(FWD_CTRL_OFS, v);
      chk("fwd rw", v, fc);
      rd(DEF_TAG_OFS, v);
      chk("tag rw", v, dt);
      rd(LIM_CTRL_OFS, v);
      chk("limit rw", v, lm & 16'h001F);
      @(posedge clk_sys_in);
      {an_pause_in, half_duplex_in, rx_tagged_in, rx_bcast_in, rx_mcast_in, rx_flood_in,
       tx_arrived_untagged_in, tx_insert_en_in, rx_prio_in, rx_vlan_member_in,
       rx_dest_mask_in} <= 17'($urandom);
      rx_vid_in <= (i % 3) ? dt[11:0] : ((i % 5) ? 12'($urandom) : NULL_VID);
      rx_len_in <= 11'($urandom);
      tx_len_in <= 11'($urandom);
      tx_ingress_tag_in <= 16'($urandom);
      rx_valid_in <= 1'b1;
      tx_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      rx_valid_in <= 1'b0;
      tx_valid_in <= 1'b0;
      #1;
      ev = (!rx_tagged_in || rx_vid_in == NULL_VID) ? dt[11:0] : rx_vid_in;
      dr = !fc[FC_RX_EN] || (fc[FC_VLAN_FILT] && !rx_vlan_member_in[PORT_TWO_BIT])
        || (fc[FC_NON_DEF_VID_DROP] && ev != dt[11:0]);
      chk("drop", rx_drop_out, dr);
      chk("vid", rx_vid_out, ev);
      chk("mask", rx_fwd_mask_out, dr ? 3'h0 : rx_dest_mask_in & fc[2:0]);
      chk("learn", rx_learn_out, !dr && !fc[FC_LEARN_DIS]);
      chk("rx mon", rx_monitor_out, !dr && fc[FC_RX_SNIFF]);
      if (rx_tagged_in) chk("prio", rx_prio_out, (fc[FC_PRIO_CEIL] && rx_prio_in > dt[15:13]) ? dt[15:13] : rx_prio_in);
      chk("rx bytes", rx_rate_bytes_out, rate(rx_len_in));
      chk("tx bytes", tx_rate_bytes_out, rate(tx_len_in));
      if (!dr) chk("count", rx_limit_count_out, cnt());
      chk("tx send", tx_send_out, fc[FC_TX_EN]);
      chk("tx mon", tx_monitor_out, fc[FC_TX_EN] && fc[FC_TX_SNIFF]);
      chk("add tag", tx_add_tag_out, tx_insert_en_in && tx_arrived_untagged_in);
      chk("tag", tx_tag_out, tx_ingress_tag_in);
      chk("flow", flow_ctrl_en_out, fc[FC_FORCE_FLOW] || an_pause_in);
      chk("bp", back_pressure_out, fc[FC_BACK_PRESS] && half_duplex_in);
      chk("sniffer", sniffer_port_out, fc[FC_SNIFFER]);
      chk("mode", limit_mode_out, lm[3:2]);
      chk("dtag", default_tag_out, dt);
      chk("rx done", rx_done_out, 1'b1);
      chk("tx done", tx_done_out, 1'b1);
      chk("rx en", rx_enable_out, fc[FC_RX_EN]);
      chk("tx en", tx_enable_out, fc[FC_TX_EN]);
      @(posedge clk_sys_in);
      #1;
      chk("rx pulse", rx_done_out | rx_drop_out | rx_learn_out, 1'b0);
      chk("tx pulse", tx_done_out | tx_send_out | tx_monitor_out, 1'b0);
    end
    $display("test random traffic done");
    // mid-run reset must bring back every default
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("flow rst", flow_ctrl_en_out, 1'b0);
    chk("tx en rst", tx_enable_out, 1'b1);
    chk("rx en rst", rx_enable_out, 1'b1);
    chk("dtag rst", default_tag_out, DEF_TAG_RST);
    @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(FWD_CTRL_OFS, v);
    chk("fwd rerst", v, FWD_CTRL_RST);
    rd(LIM_CTRL_OFS, v);
    chk("limit rerst", v, 16'h0000);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : tb
